/* hw/wwd_top.sv */
// wwd_top: windowed watchdog, 16-bit up-counter with prescaler, reload,
// early-service window and single-cycle reset request.
// assumes software drives the register port synchronously to ref_clk and
// the wake-up oscillator clock arrives as a slow level on an input.
//
// Local design decisions: the plain strobed port and the placing of the registers.

// Operation
// [RQ1] watchdog runs right after every reset
// [RQ2] off/on instructions stop and restart anytime; here both are ignored once the watchdog has tripped
// [RQ3] overflow without service raises reset request
// [RQ4] service inside forbidden window raises reset
// [RQ5] sixteen-bit upward counter, overflow past maximum
// [RQ6] system or wake-up clock, divide 16384/256
// [RQ7] counter loads from programmable reload register
// [RQ8] every valid service reloads current reload value
// [RQ9] defaults give about 0.13 s interval
// [RQ10] request is one-cycle pulse, counter then stops
module wwd_top
    import wwd_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // dedicated instructions, one-cycle pulses
    input wire logic watchdog_off_instruction,
    input wire logic watchdog_on_instruction,
    // slow oscillator level, sampled here
    input wire logic wakeup_osc_clock,
    // system side
    output logic wdt_reset_req,
    output logic wdt_enabled
);

    // register file state
    logic [CTRL_W-1:0] ctrl_r;
    logic [CNT_W-1:0] reload_r;
    logic [CNT_W-1:0] window_r;
    logic [CNT_W-1:0] count_r;
    logic [PRE_W-1:0] presc_r;
    logic ovf_seen_r;
    logic early_seen_r;
    wwd_state_t state_r;

    // wake-up clock synchroniser and edge detect
    logic wu_meta_r;
    logic wu_sync_r;
    logic wu_prev_r;
    logic wu_edge;

    // decoded strobes
    logic wr_ctrl;
    logic wr_reload;
    logic wr_window;
    logic service;
    logic running;
    logic src_tick;
    logic pre_last;
    logic cnt_step;
    logic overflow;
    logic early;
    logic trip;

    assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    assign wr_reload = reg_wr && (reg_addr == OFS_RELOAD);
    assign wr_window = reg_wr && (reg_addr == OFS_WINDOW);
    assign service = reg_wr && (reg_addr == OFS_SERVICE);

    assign running = (state_r == WS_RUN);

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wu_meta_r <= 1'b0;
            wu_sync_r <= 1'b0;
            wu_prev_r <= 1'b0;
        end
        else
        begin
            wu_meta_r <= wakeup_osc_clock;
            wu_sync_r <= wu_meta_r;
            wu_prev_r <= wu_sync_r;
        end
    end

    assign wu_edge = wu_sync_r && !wu_prev_r;

    // source selection: system clock ticks every cycle
    assign src_tick = (ctrl_r[CTRL_CLKSEL_BIT] == CLKSEL_SYSTEM) ? 1'b1
                    : wu_edge; // see [RQ6]
    // /256 uses >= so a switch from /16384 mid-count still wraps
    assign pre_last = (ctrl_r[CTRL_PRESEL_BIT] == PRESEL_256)
                    ? (presc_r >= PRE_LAST_256)
                    : (presc_r == PRE_LAST_16384); // see [RQ6]
    assign cnt_step = running && src_tick && pre_last;

    // overflow: count at maximum and about to step past it
    assign overflow = cnt_step && (count_r == CNT_MAX); // see [RQ3] [RQ5]
    // a service below the window boundary is too early
    assign early = running && service && (count_r < window_r); // see [RQ4]
    assign trip = overflow || early;

    // control registers
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_r <= CTRL_RST; // see [RQ9]
            reload_r <= RELOAD_RST; // see [RQ9]
            window_r <= WINDOW_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_r <= reg_wdata[CTRL_W-1:0];
            end
            if (wr_reload)
            begin
                reload_r <= reg_wdata[CNT_W-1:0]; // see [RQ7]
            end
            if (wr_window)
            begin
                window_r <= reg_wdata[CNT_W-1:0]; // see [RQ4]
            end
        end
    end

    // run state: on after reset, instructions toggle, trip is final
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= WS_RUN; // see [RQ1]
        end
        else
        begin
            case (state_r)
                WS_RUN:
                begin
                    if (trip)
                    begin
                        state_r <= WS_TRIP; // see [RQ10]
                    end
                    else if (watchdog_off_instruction)
                    begin
                        state_r <= WS_OFF; // see [RQ2]
                    end
                end
                WS_OFF:
                begin
                    // off beats on when both arrive together
                    if (watchdog_on_instruction &&
                        !watchdog_off_instruction)
                    begin
                        state_r <= WS_RUN; // see [RQ2]
                    end
                end
                WS_TRIP:
                begin
                    state_r <= WS_TRIP; // see [RQ10]
                end
                default:
                begin
                    state_r <= WS_TRIP;
                end
            endcase
        end
    end

    // prescaler restarts on service so a fresh interval is whole
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            presc_r <= '0;
        end
        else if (service || !running)
        begin
            presc_r <= '0;
        end
        else if (src_tick)
        begin
            presc_r <= pre_last ? '0 : presc_r + 1'b1; // see [RQ6]
        end
    end

    // watchdog counter
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            count_r <= RELOAD_RST; // see [RQ1] [RQ7]
        end
        // frozen on trip so software can still read where it stopped
        else if (state_r == WS_TRIP || trip)
        begin
            count_r <= count_r; // see [RQ10]
        end
        // a watchdog that is off reloads too, with no window check
        else if (service)
        begin
            count_r <= reload_r; // see [RQ8]
        end
        else if (cnt_step)
        begin
            count_r <= count_r + 1'b1; // see [RQ5]
        end
    end

    // single-cycle request; trip is entered only once per reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wdt_reset_req <= 1'b0;
        end
        else
        begin
            wdt_reset_req <= trip; // see [RQ3] [RQ4] [RQ10]
        end
    end

    // sticky cause flags, cleared by reset only
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ovf_seen_r <= 1'b0;
            early_seen_r <= 1'b0;
        end
        else
        begin
            if (overflow)
            begin
                ovf_seen_r <= 1'b1;
            end
            if (early)
            begin
                early_seen_r <= 1'b1;
            end
        end
    end

    // registered, so it follows the run state one cycle late
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wdt_enabled <= 1'b1; // see [RQ1]
        end
        else
        begin
            wdt_enabled <= (state_r != WS_OFF); // see [RQ2]
        end
    end

    // read data, one cycle after the read strobe; unmapped reads zero
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= '0;
        end
        else if (reg_rd)
        begin
            reg_rdata <= '0;
            if (reg_addr == OFS_CTRL)
            begin
                reg_rdata[CTRL_W-1:0] <= ctrl_r;
            end
            else if (reg_addr == OFS_RELOAD)
            begin
                reg_rdata[CNT_W-1:0] <= reload_r;
            end
            else if (reg_addr == OFS_WINDOW)
            begin
                reg_rdata[CNT_W-1:0] <= window_r;
            end
            else if (reg_addr == OFS_COUNT)
            begin
                reg_rdata[CNT_W-1:0] <= count_r;
            end
            else if (reg_addr == OFS_STATUS)
            begin
                reg_rdata[STAT_ENABLED_BIT] <= (state_r == WS_RUN);
                reg_rdata[STAT_TRIPPED_BIT] <= (state_r == WS_TRIP);
                reg_rdata[STAT_OVF_BIT] <= ovf_seen_r;
                reg_rdata[STAT_EARLY_BIT] <= early_seen_r;
            end
        end
        else
        begin
            reg_rdata <= '0;
        end
    end

endmodule : wwd_top

/* hw/wwd_pkg.sv */
// wwd_pkg: register map, field positions, reset values and states of the
// windowed watchdog.
// assumes a single 250 MHz clock and a plain address/strobe register port.
package wwd_pkg;

    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int PRE_W = 14;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_WINDOW = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SERVICE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

    // control register fields
    localparam int CTRL_CLKSEL_BIT = 0;
    localparam int CTRL_PRESEL_BIT = 1;
    localparam int CTRL_W = 2;

    // status register fields
    localparam int STAT_ENABLED_BIT = 0;
    localparam int STAT_TRIPPED_BIT = 1;
    localparam int STAT_OVF_BIT = 2;
    localparam int STAT_EARLY_BIT = 3;

    // clock source and prescale encodings
    localparam logic CLKSEL_SYSTEM = 1'b0;
    localparam logic CLKSEL_WAKEUP = 1'b1;
    localparam logic PRESEL_16384 = 1'b0;
    localparam logic PRESEL_256 = 1'b1;
    localparam logic [PRE_W-1:0] PRE_LAST_16384 = 14'h3FFF;
    localparam logic [PRE_W-1:0] PRE_LAST_256 = 14'h00FF;

    // default timing: wake-up clock, divide by 16384, four counter steps
    localparam real WAKEUP_FREQ_HZ = 500000.0;
    localparam real DEFAULT_INTERVAL_S = 0.13;
    localparam int DEFAULT_STEPS = int'(DEFAULT_INTERVAL_S * WAKEUP_FREQ_HZ
                                        / 16384.0);
    localparam logic [CNT_W-1:0] RELOAD_RST = 16'hFFFF
                                 - CNT_W'(DEFAULT_STEPS) + 16'h0001;
    localparam logic [CTRL_W-1:0] CTRL_RST = {PRESEL_16384, CLKSEL_WAKEUP};
    localparam logic [CNT_W-1:0] WINDOW_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        WS_RUN,
        WS_OFF,
        WS_TRIP
    } wwd_state_t;

endpackage : wwd_pkg

/* verification/wwd_top_assertions.sv */
// wwd_chk: port-level properties of the windowed watchdog.
// assumes it is bound onto wwd_top, one ref_clk domain.
module wwd_chk
    import wwd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic watchdog_off_instruction,
    input wire logic watchdog_on_instruction,
    input wire logic wdt_reset_req,
    input wire logic wdt_enabled
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    logic trip_seen_r;
    // only rst may clear a trip, so one request per reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            trip_seen_r <= 1'b0;
        else if (wdt_reset_req)
            trip_seen_r <= 1'b1;
    end
    AST_ONCE: assert property (trip_seen_r |-> !wdt_reset_req)
        else $error("second reset request");
    AST_RST: assert property ($fell(rst)
        |-> wdt_enabled && !wdt_reset_req)
        else $error("not running after reset");
    // wdt_enabled is registered from the run state: two edges after a pulse
    AST_ON: assert property (watchdog_on_instruction
        && !watchdog_off_instruction |-> ##2 wdt_enabled)
        else $error("on instruction ignored");
    AST_OFF: assert property (watchdog_off_instruction
        && !trip_seen_r && !wdt_reset_req
        |-> ##2 (!wdt_enabled || trip_seen_r))
        else $error("off instruction ignored");
    AST_STOP: assert property (!wdt_enabled [*2]
        |-> !wdt_reset_req)
        else $error("request while stopped");
    AST_RDZERO: assert property (!$past(reg_rd)
        |-> reg_rdata == '0)
        else $error("read data outside answer cycle");
    AST_UNMAP: assert property (reg_rd && reg_addr > OFS_STATUS
        |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    AST_HIGH: assert property (reg_rd
        |=> reg_rdata[DATA_W-1:CNT_W] == '0)
        else $error("upper read bits set");
    COV_REQ: cover property (wdt_reset_req);
    COV_OFF: cover property (!wdt_enabled);
    COV_ON: cover property (!wdt_enabled ##1 wdt_enabled);
endmodule : wwd_chk

bind wwd_top wwd_chk u_chk (.ref_clk, .rst, .reg_addr, .reg_rd, .reg_rdata,
    .watchdog_off_instruction, .watchdog_on_instruction, .wdt_reset_req,
    .wdt_enabled);

/* verification/wwd_top_tb_top.sv */
// wwd_top_tb_top: directed register-port tests of the watchdog.
// assumes wwd_top with its checker bound; runs from the system and wake-up clocks, /256 and /16384.
module wwd_top_tb_top
    import wwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, osc = 0;
    logic off_i = 0, on_i = 0, req, en;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, d, d2;
    int errors = 0, checks = 0, req_cnt = 0, cyc;
    logic [ADDR_W-1:0] ta [6] = '{OFS_CTRL, OFS_RELOAD, OFS_WINDOW,
        OFS_COUNT, OFS_STATUS, 8'h20};
    logic [DATA_W-1:0] te [6] = '{32'h0000_0001, 32'h0000_FFFC,
        32'h0000_0000, 32'h0000_FFFC, 32'h0000_0001, 32'h0000_0000};
    wwd_top uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .watchdog_off_instruction(off_i),
        .watchdog_on_instruction(on_i), .wakeup_osc_clock(osc),
        .wdt_reset_req(req), .wdt_enabled(en));
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        if (req === 1'b1)
            req_cnt++;
    end
    task chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge ref_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask : wr
    task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge ref_clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 0;
        #1 v = reg_rdata;
    endtask : rd
    task pulse(input logic off);
        @(posedge ref_clk);
        off_i <= off;
        on_i <= !off;
        @(posedge ref_clk);
        off_i <= 0;
        on_i <= 0;
        // the enabled output follows the run state one edge later
        @(posedge ref_clk);
        #1;
    endtask : pulse
    task do_reset;
        rst <= 1;
        repeat (6) @(posedge ref_clk);
        rst <= 0;
        req_cnt = 0;
    endtask : do_reset
    task wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // all tests take about 22,000 cycles; the 50,000-cycle limit allows over twice that
    initial
    begin
        #200000;
        errors++;
        wrap_up();
    end
    initial
    begin
        do_reset();
        chk(DATA_W'(en), 32'h0000_0001);
        for (int i = 0; i < 6; i++)
        begin
            rd(ta[i], d);
            chk(d, te[i]);
        end
        $display("test defaults done");
        wr(OFS_CTRL, 32'h0000_0002);
        wr(OFS_RELOAD, 32'h0000_FFFF);
        wr(OFS_SERVICE, 32'h0000_0000);
        rd(OFS_COUNT, d);
        chk(d, 32'h0000_FFFF);
        cyc = 0;
        while (req_cnt == 0 && cyc < 1000)
        begin
            @(posedge ref_clk);
            cyc++;
        end
        // one step of 256 cycles; loop and counter may race by one edge
        chk(DATA_W'(cyc > 253 && cyc < 258), 32'h0000_0001);
        rd(OFS_STATUS, d);
        chk(d & 32'h0000_000E, 32'h0000_0006);
        rd(OFS_COUNT, d);
        repeat (300) @(posedge ref_clk);
        rd(OFS_COUNT, d2);
        chk(d2, d);
        chk(d2, 32'h0000_FFFF);
        chk(DATA_W'(req_cnt), 32'h0000_0001);
        $display("test overflow done");
        // wake-up input idle, so the default setup holds the count still
        do_reset();
        wr(OFS_WINDOW, 32'h0000_FFF0);
        wr(OFS_RELOAD, 32'h0000_1234);
        wr(OFS_SERVICE, 32'h0000_0000);
        rd(OFS_COUNT, d);
        chk(d, 32'h0000_1234);
        chk(DATA_W'(req_cnt), 32'h0000_0000);
        wr(OFS_SERVICE, 32'h0000_0000);
        repeat (3) @(posedge ref_clk);
        chk(DATA_W'(req_cnt), 32'h0000_0001);
        rd(OFS_STATUS, d);
        chk(d & 32'h0000_000E, 32'h0000_000A);
        $display("test early service done");
        do_reset();
        wr(OFS_CTRL, 32'h0000_0002);
        pulse(1);
        chk(DATA_W'(en), 32'h0000_0000);
        rd(OFS_COUNT, d);
        repeat (1200) @(posedge ref_clk);
        rd(OFS_COUNT, d2);
        chk(d2, d);
        chk(d2, 32'h0000_FFFC);
        chk(DATA_W'(req_cnt), 32'h0000_0000);
        pulse(0);
        chk(DATA_W'(en), 32'h0000_0001);
        repeat (1300) @(posedge ref_clk);
        chk(DATA_W'(req_cnt), 32'h0000_0001);
        $display("test off on done");
        // window equal to the count: the boundary itself is a legal service
        do_reset();
        wr(OFS_WINDOW, 32'h0000_FFFC);
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_RELOAD, 32'h0000_FFFF);
        wr(OFS_SERVICE, 32'h0000_0000);
        repeat (16370) @(posedge ref_clk);
        chk(DATA_W'(req_cnt), 32'h0000_0000);
        repeat (30) @(posedge ref_clk);
        chk(DATA_W'(req_cnt), 32'h0000_0001);
        rd(OFS_STATUS, d);
        chk(d & 32'h0000_000E, 32'h0000_0006);
        $display("test system clock divide 16384 done");
        do_reset();
        wr(OFS_CTRL, 32'h0000_0003);
        wr(OFS_RELOAD, 32'h0000_0000);
        wr(OFS_SERVICE, 32'h0000_0000);
        repeat (256)
        begin
            osc <= 1;
            repeat (4) @(posedge ref_clk);
            osc <= 0;
            repeat (4) @(posedge ref_clk);
        end
        repeat (10) @(posedge ref_clk);
        rd(OFS_COUNT, d);
        chk(d, 32'h0000_0001);
        $display("test wake-up clock done");
        wrap_up();
    end
endmodule : wwd_top_tb_top
